// File: icm_map.vh
`ifndef ICM_MAP_VH
`define ICM_MAP_VH
// ==========================================
// register byte offsets
`define ICM_REG_CTRL 8'h00
`define ICM_REG_MODES 8'h04
`define ICM_REG_TUNE 8'h08
`define ICM_REG_UPDATE 8'h0C
`define ICM_REG_STATUS 8'h10
`define ICM_REG_ACTIVE 8'h14
// ==========================================
// control register fields
`define ICM_CTRL_STAGE_EN_LSB 0
`define ICM_CTRL_PREMOD_BIT 3
`define ICM_CTRL_OSC_EN_BIT 4
`define ICM_CTRL_RESET 5'h00
// ==========================================
// coarse modulation codes, three bits per stage
`define ICM_MODE_W 3
`define ICM_MODE_NONE 3'h0
`define ICM_MODE_HALF 3'h1
`define ICM_MODE_QUARTER 3'h2
`define ICM_MODE_THREEQ 3'h3
`define ICM_MODE_EIGHTH 3'h4
`define ICM_MODES_RESET 9'h000
`define ICM_TUNE_RESET 32'h00000000
// ==========================================
// sqrt(2)/2 in q15
`define ICM_RHALF 18'h05A82
`endif

// File: icm_rotator.v
`timescale 1ns/1ps
`include "icm_map.vh"
// ==========================================
// rotates a complex sample by a multiple of 45 degrees
module icm_rotator (
  input wire core_clk_in,
  input wire rst_in,
  input wire en_in,
  input wire [2:0] angle_in,
  input wire signed [15:0] i_in,
  input wire signed [15:0] q_in,
  output reg signed [15:0] i_out,
  output reg signed [15:0] q_out
);
  reg signed [1:0] c_sgn;
  reg signed [1:0] s_sgn;
  wire signed [17:0] i_x = {{2{i_in[15]}}, i_in};
  wire signed [17:0] q_x = {{2{q_in[15]}}, q_in};
  wire signed [17:0] sum_i;
  wire signed [17:0] sum_q;
  wire signed [35:0] prod_i;
  wire signed [35:0] prod_q;
  wire signed [17:0] res_i;
  wire signed [17:0] res_q;

  function signed [17:0] term;
    input signed [17:0] x;
    input signed [1:0] sgn;
    begin
      if (sgn == 2'sb01)
        term = x;
      else if (sgn == 2'sb11)
        term = -x;
      else
        term = 18'sh00000;
    end
  endfunction

  function signed [15:0] sat16;
    input signed [17:0] x;
    begin
      if (x > 18'sh07FFF)
        sat16 = 16'sh7FFF;
      else if (x < -18'sh08000)
        sat16 = -16'sh8000;
      else
        sat16 = x[15:0];
    end
  endfunction

  // cosine and sine signs for each eighth of a turn
  always @* begin
    case (angle_in)
      3'h0: begin c_sgn = 2'sb01; s_sgn = 2'sb00; end
      3'h1: begin c_sgn = 2'sb01; s_sgn = 2'sb01; end
      3'h2: begin c_sgn = 2'sb00; s_sgn = 2'sb01; end
      3'h3: begin c_sgn = 2'sb11; s_sgn = 2'sb01; end
      3'h4: begin c_sgn = 2'sb11; s_sgn = 2'sb00; end
      3'h5: begin c_sgn = 2'sb11; s_sgn = 2'sb11; end
      3'h6: begin c_sgn = 2'sb00; s_sgn = 2'sb11; end
      default: begin c_sgn = 2'sb01; s_sgn = 2'sb11; end
    endcase
  end

  // odd eighths carry the r factor on the summed pair
  assign sum_i = term(i_x, c_sgn) + term(q_x, s_sgn);
  assign sum_q = term(q_x, c_sgn) - term(i_x, s_sgn);
  assign prod_i = sum_i * $signed(`ICM_RHALF);
  assign prod_q = sum_q * $signed(`ICM_RHALF);
  assign res_i = angle_in[0] ? prod_i[32:15] : sum_i;
  assign res_q = angle_in[0] ? prod_q[32:15] : sum_q;

  // saturate rather than wrap: i+q may exceed full scale
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      i_out <= 16'sh0000;
      q_out <= 16'sh0000;
    end else if (en_in) begin
      i_out <= sat16(res_i);
      q_out <= sat16(res_q);
    end
  end
endmodule // icm_rotator

// File: icm_interp_path.v
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "icm_map.vh"
// Contract
// - half-rate mode negates every second sample on both channels, no swapping.
// - quarter-rate: I gives I,Q,-I,-Q; Q gives Q,-I,-Q,I.
// - three-quarter-rate: I gives I,-Q,-I,Q; Q gives Q,I,-Q,-I.
// - of the shifting modes only half-rate keeps channels apart; the others need complex input.
// - coarse shifts are fractions of output rate, done inside the stages.
// - each enabled half-band stage doubles its input sample rate.
// - premodulation shifts input by half the data rate before stage one.
// - fine oscillator carrier comes from a 32-bit phase tuning word.
// - oscillator runs at data rate, or twice it with stage one on.
// - tuning word takes effect only on 0-to-1 of update bit 0.
module icm_interp_path (
  input wire core_clk_in,
  input wire rst_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  input wire signed [15:0] sample_i_in,
  input wire signed [15:0] sample_q_in,
  input wire sample_valid_in,
  output wire sample_ready_out,
  output wire signed [15:0] out_i_out,
  output wire signed [15:0] out_q_out,
  output reg out_valid_out
);
  // ==========================================
  // configuration registers
  reg [4:0] ctrl;
  reg [8:0] modes;
  reg [31:0] tune_word;
  reg [31:0] active_word;
  reg update_bit;
  reg [2:0] cnt;
  wire [2:0] stage_en = ctrl[`ICM_CTRL_STAGE_EN_LSB +: 3];
  wire mode_wr = reg_wr_in && (reg_addr_in == `ICM_REG_MODES || reg_addr_in == `ICM_REG_CTRL);

  // writes; the tuning word waits for a rising update bit
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl <= `ICM_CTRL_RESET;
      modes <= `ICM_MODES_RESET;
      tune_word <= `ICM_TUNE_RESET;
      active_word <= `ICM_TUNE_RESET;
      update_bit <= 1'b0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `ICM_REG_CTRL: ctrl <= reg_wdata_in[4:0];
        `ICM_REG_MODES: modes <= reg_wdata_in[8:0];
        `ICM_REG_TUNE: tune_word <= reg_wdata_in;
        `ICM_REG_UPDATE: begin
          update_bit <= reg_wdata_in[0];
          if (!update_bit && reg_wdata_in[0])
            active_word <= tune_word;
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // rate ticks: cnt wraps at the interpolation factor
  function [2:0] en_count;
    input [2:0] en;
    input [1:0] upto;
    begin
      en_count = 3'h0;
      if (upto >= 2'd1 && en[0])
        en_count = en_count + 3'h1;
      if (upto >= 2'd2 && en[1])
        en_count = en_count + 3'h1;
      if (upto >= 2'd3 && en[2])
        en_count = en_count + 3'h1;
    end
  endfunction

  function tick_at;
    input [2:0] c;
    input [2:0] en;
    input [1:0] upto;
    reg [3:0] period;
    begin
      period = 4'h8 >> (3'h3 - en_count(en, 2'd3) + en_count(en, upto));
      tick_at = ((c & (period[2:0] - 3'h1)) == 3'h0);
    end
  endfunction

  wire [3:0] factor = 4'h1 << en_count(stage_en, 2'd3);
  wire [3:0] tick; // tick[0] input rate, tick[n] rate after stage n
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tick
      assign tick[g] = tick_at(cnt, stage_en, g[1:0]);
    end
  endgenerate

  // counter restarts with the configuration so ticks realign
  always @(posedge core_clk_in) begin
    if (rst_in || mode_wr)
      cnt <= 3'h0;
    else if (cnt == factor[2:0] - 3'h1 || factor == 4'h1)
      cnt <= 3'h0;
    else
      cnt <= cnt + 3'h1;
  end

  assign sample_ready_out = tick[0];

  // ==========================================
  // modulation step counters and angles
  function [2:0] coarse_angle;
    input [2:0] mode;
    input [2:0] step;
    begin
      case (mode)
        `ICM_MODE_HALF: coarse_angle = {step[0], 2'b00};
        `ICM_MODE_QUARTER: coarse_angle = {step[1:0], 1'b0};
        `ICM_MODE_THREEQ: coarse_angle = {step[1:0], 1'b0} + {step[1:0], 1'b0} + {step[1:0], 1'b0};
        `ICM_MODE_EIGHTH: coarse_angle = step;
        default: coarse_angle = 3'h0;
      endcase
    end
  endfunction

  reg [2:0] step [0:2];
  reg premod_step;
  reg [31:0] phase;

  // steps clear on mode writes, phase accumulates the active word
  always @(posedge core_clk_in) begin
    if (rst_in || mode_wr) begin
      step[0] <= 3'h0;
      step[1] <= 3'h0;
      step[2] <= 3'h0;
      premod_step <= 1'b0;
      phase <= 32'h00000000;
    end else begin
      if (tick[0])
        premod_step <= ~premod_step;
      if (tick[1])
        phase <= phase + active_word;
      if (tick[1])
        step[0] <= step[0] + 3'h1;
      if (tick[2])
        step[1] <= step[1] + 3'h1;
      if (tick[3])
        step[2] <= step[2] + 3'h1;
    end
  end

  // ==========================================
  // input capture and premodulation
  wire signed [15:0] in_i = sample_valid_in ? sample_i_in : 16'sh0000;
  wire signed [15:0] in_q = sample_valid_in ? sample_q_in : 16'sh0000;
  wire signed [15:0] pre_i;
  wire signed [15:0] pre_q;

  icm_rotator u_premod (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .en_in(tick[0]),
    .angle_in(ctrl[`ICM_CTRL_PREMOD_BIT] ? {premod_step, 2'b00} : 3'h0),
    .i_in(in_i),
    .q_in(in_q),
    .i_out(pre_i),
    .q_out(pre_q)
  );

  // ==========================================
  // half-band stages with coarse mixers
  wire signed [15:0] st_i [0:3];
  wire signed [15:0] st_q [0:3];
  wire signed [15:0] osc_i;
  wire signed [15:0] osc_q;
  assign st_i[0] = pre_i;
  assign st_q[0] = pre_q;

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_stage
      reg signed [15:0] prev_i;
      reg signed [15:0] prev_q;
      reg signed [15:0] cur_i;
      reg signed [15:0] cur_q;
      reg signed [15:0] hb_i;
      reg signed [15:0] hb_q;
      wire signed [16:0] mid_i = {prev_i[15], prev_i} + {cur_i[15], cur_i};
      wire signed [16:0] mid_q = {prev_q[15], prev_q} + {cur_q[15], cur_q};
      wire signed [15:0] src_i = (g == 1) ? osc_i : st_i[g];
      wire signed [15:0] src_q = (g == 1) ? osc_q : st_q[g];

      // new input lands on the slow tick, midpoint fills the fast tick
      always @(posedge core_clk_in) begin
        if (rst_in) begin
          prev_i <= 16'sh0000;
          prev_q <= 16'sh0000;
          cur_i <= 16'sh0000;
          cur_q <= 16'sh0000;
          hb_i <= 16'sh0000;
          hb_q <= 16'sh0000;
        end else if (!stage_en[g]) begin
          if (tick[g]) begin
            hb_i <= src_i;
            hb_q <= src_q;
          end
        end else if (tick[g + 1]) begin
          if (tick[g]) begin
            prev_i <= cur_i;
            prev_q <= cur_q;
            cur_i <= src_i;
            cur_q <= src_q;
            hb_i <= cur_i;
            hb_q <= cur_q;
          end else begin
            hb_i <= mid_i[16:1];
            hb_q <= mid_q[16:1];
          end
        end
      end

      // mixing happens at the stage output rate, so shifts scale with it
      icm_rotator u_mix (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .en_in(tick[g + 1]),
        .angle_in(stage_en[g] ? coarse_angle(modes[3 * g +: 3], step[g]) : 3'h0),
        .i_in(hb_i),
        .q_in(hb_q),
        .i_out(st_i[g + 1]),
        .q_out(st_q[g + 1])
      );
    end
  endgenerate

  // ==========================================
  // fine oscillator after stage one; coarse eighth-turn carrier
  icm_rotator u_osc (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .en_in(tick[1]),
    .angle_in(ctrl[`ICM_CTRL_OSC_EN_BIT] ? 3'h0 - phase[31:29] : 3'h0),
    .i_in(st_i[1]),
    .q_in(st_q[1]),
    .i_out(osc_i),
    .q_out(osc_q)
  );

  assign out_i_out = st_i[3];
  assign out_q_out = st_q[3];

  // output stands valid in the cycle after every final-rate tick, once out of reset
  always @(posedge core_clk_in) begin
    if (rst_in)
      out_valid_out <= 1'b0;
    else
      out_valid_out <= tick[3];
  end

  // ==========================================
  // reads: data in the cycle after the strobe, zero elsewhere
  always @(posedge core_clk_in) begin
    if (rst_in)
      reg_rdata_out <= 32'h00000000;
    else if (reg_rd_in) begin
      case (reg_addr_in)
        `ICM_REG_CTRL: reg_rdata_out <= {27'h0000000, ctrl};
        `ICM_REG_MODES: reg_rdata_out <= {23'h000000, modes};
        `ICM_REG_TUNE: reg_rdata_out <= tune_word;
        `ICM_REG_UPDATE: reg_rdata_out <= {31'h00000000, update_bit};
        `ICM_REG_STATUS: reg_rdata_out <= {19'h00000, factor, step[2], step[1], step[0]};
        `ICM_REG_ACTIVE: reg_rdata_out <= active_word;
        default: reg_rdata_out <= 32'h00000000;
      endcase
    end else
      reg_rdata_out <= 32'h00000000;
  end
endmodule // icm_interp_path

// File: icm_host_drv.sv
`timescale 1ns/1ps
// ==========================================
// host side complex sample source
module icm_host_drv (
  input wire core_clk_in,
  input wire rst_in,
  input wire en_in,
  input wire signed [15:0] i_in,
  input wire signed [15:0] q_in,
  output reg signed [15:0] sample_i_out = 16'hA5A5,
  output reg signed [15:0] sample_q_out = 16'h5A5A,
  output reg sample_valid_out = 1'b0
);
  // idle data toggles every cycle so a stale sample never looks settled
  always @(posedge core_clk_in) begin
    if (rst_in || !en_in) begin
      sample_valid_out <= 1'b0;
      sample_i_out <= ~sample_i_out;
      sample_q_out <= ~sample_q_out;
    end else begin
      sample_valid_out <= 1'b1;
      sample_i_out <= i_in;
      sample_q_out <= q_in;
    end
  end
endmodule // icm_host_drv

// File: icm_chk_assertions.sv
`timescale 1ns/1ps
`include "icm_map.vh"
// ==========================================
// port checker
module icm_chk (
  input wire core_clk_in,
  input wire rst_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  input wire signed [15:0] sample_i_in,
  input wire signed [15:0] sample_q_in,
  input wire sample_ready_out,
  input wire signed [15:0] out_i_out,
  input wire signed [15:0] out_q_out,
  input wire out_valid_out
);
  reg [4:0] ctl;
  reg [8:0] mds;
  reg [31:0] stg;
  reg [31:0] act;
  reg upd;
  reg [3:0] gap;
  reg gap_ok;
  reg [4:0] calm;
  wire [3:0] fac = 4'h1 << ({1'b0, ctl[0]} + {1'b0, ctl[1]} + {1'b0, ctl[2]});
  // rotations are only judged once input and setup stayed still past the pipeline
  wire rot_ok = calm >= 5'h14 && ctl == 5'h01 && out_valid_out;
  // ==========================================
  // shadow of setup, staged word and tick spacing
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      ctl <= 5'h00;
      mds <= 9'h000;
      stg <= 32'h0;
      act <= 32'h0;
      upd <= 1'b0;
      gap <= 4'h0;
      gap_ok <= 1'b0;
      calm <= 5'h00;
    end else begin
      gap <= sample_ready_out ? 4'h1 : gap + 4'h1;
      gap_ok <= reg_wr_in ? 1'b0 : (gap_ok | sample_ready_out);
      calm <= (reg_wr_in || !$stable(sample_i_in) || !$stable(sample_q_in)) ? 5'h00 : calm + {4'h0, calm != 5'h1F};
      if (reg_wr_in && reg_addr_in == `ICM_REG_CTRL) ctl <= reg_wdata_in[4:0];
      if (reg_wr_in && reg_addr_in == `ICM_REG_MODES) mds <= reg_wdata_in[8:0];
      if (reg_wr_in && reg_addr_in == `ICM_REG_TUNE) stg <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `ICM_REG_UPDATE) begin
        upd <= reg_wdata_in[0];
        if (reg_wdata_in[0] && !upd) act <= stg;
      end
    end
  end
  // ==========================================
  // properties
  property p_rst;
    @(posedge core_clk_in) rst_in |=> !out_valid_out && sample_ready_out && reg_rdata_out == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_rd_idle;
    @(posedge core_clk_in) disable iff (rst_in) !reg_rd_in |=> reg_rdata_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_act;
    @(posedge core_clk_in) disable iff (rst_in) reg_rd_in && reg_addr_in == `ICM_REG_ACTIVE |=> reg_rdata_out == act;
  endproperty
  a_act: assert property (p_act) else $error("active tuning word wrong");
  property p_rate;
    @(posedge core_clk_in) disable iff (rst_in) gap_ok |-> sample_ready_out == (gap == fac);
  endproperty
  a_rate: assert property (p_rate) else $error("input tick spacing wrong");
  property p_half;
    @(posedge core_clk_in) disable iff (rst_in) rot_ok && mds[2:0] == `ICM_MODE_HALF
      |-> out_i_out == -$past(out_i_out) && out_q_out == -$past(out_q_out);
  endproperty
  a_half: assert property (p_half) else $error("half rate sequence wrong");
  property p_quarter;
    @(posedge core_clk_in) disable iff (rst_in) rot_ok && mds[2:0] == `ICM_MODE_QUARTER
      |-> out_i_out == $past(out_q_out) && out_q_out == -$past(out_i_out);
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter rate sequence wrong");
  property p_threeq;
    @(posedge core_clk_in) disable iff (rst_in) rot_ok && mds[2:0] == `ICM_MODE_THREEQ
      |-> out_i_out == -$past(out_q_out) && out_q_out == $past(out_i_out);
  endproperty
  a_threeq: assert property (p_threeq) else $error("three quarter sequence wrong");
  property p_eighth;
    @(posedge core_clk_in) disable iff (rst_in) rot_ok && mds[2:0] == `ICM_MODE_EIGHTH
      |-> $unsigned(out_i_out - $past(out_q_out, 2) + 16'sh0001) <= 16'h0002
      && $unsigned(out_q_out + $past(out_i_out, 2) + 16'sh0001) <= 16'h0002;
  endproperty
  a_eighth: assert property (p_eighth) else $error("eighth rate sequence wrong");
endmodule // icm_chk
bind icm_interp_path icm_chk chk_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .sample_i_in(sample_i_in), .sample_q_in(sample_q_in), .sample_ready_out(sample_ready_out),
  .out_i_out(out_i_out), .out_q_out(out_q_out), .out_valid_out(out_valid_out));

// File: tb_top.sv
`timescale 1ns/1ps
`include "icm_map.vh"
module tb_top;
  reg core_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg hen = 1'b0;
  reg signed [15:0] hi = 16'h0000;
  reg signed [15:0] hq = 16'h0000;
  reg [15:0] lf = 16'h8B46;
  wire [31:0] rdata;
  wire signed [15:0] si, sq, oi, oq;
  wire sv, srdy, ov;
  integer bad_count = 0, compares = 0, n, k, m, ei, eq, t;
  always #12.5 core_clk_in = ~core_clk_in;
  icm_host_drv host_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .en_in(hen), .i_in(hi), .q_in(hq),
    .sample_i_out(si), .sample_q_out(sq), .sample_valid_out(sv));
  icm_interp_path dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .sample_i_in(si), .sample_q_in(sq),
    .sample_valid_in(sv), .sample_ready_out(srdy), .out_i_out(oi), .out_q_out(oq), .out_valid_out(ov));
  // ==========================================
  // shared helpers
  function [15:0] nxt(input [15:0] l);
    nxt = {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction
  // eighth-turn term: r in fixed point, rounded down like a plain shift
  function [15:0] r45(input integer s);
    integer p;
    begin
      p = `ICM_RHALF;
      p = p * s;
      r45 = p[30:15];
    end
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge core_clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_in);
      wr <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    begin
      @(posedge core_clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_in);
      rd <= 1'b0;
      #1 check(rdata, e);
    end
  endtask
  // model step: half negates, quarter and eighth-by-two turn one way, three quarter the other
  task rot(input integer md);
    begin
      t = ei;
      if (md == 1) begin
        ei = -ei;
        eq = -eq;
      end else if (md == 3) begin
        ei = -eq;
        eq = t;
      end else begin
        ei = eq;
        eq = -t;
      end
    end
  endtask
  // constant random input, then every result compared with the model orbit
  task stream(input integer md, input integer cw, input integer sm);
    begin
      lf = nxt(lf);
      hi <= {{4{lf[11]}}, lf[11:0]};
      ei = $signed({{4{lf[11]}}, lf[11:0]});
      lf = nxt(lf);
      hq <= {{4{lf[11]}}, lf[11:0]};
      eq = $signed({{4{lf[11]}}, lf[11:0]});
      wr_reg(`ICM_REG_CTRL, cw);
      wr_reg(`ICM_REG_MODES, md);
      repeat (30) @(posedge core_clk_in);
      #1 check(ov, 1'b1);
      for (k = 0; k < 8 && (oi !== ei[15:0] || oq !== eq[15:0]); k = k + 1) begin
        rot(sm);
        if (k == 3) begin
          @(posedge core_clk_in);
          #1;
        end
      end
      for (n = 0; n < 12; n = n + 1) begin
        check({16'h0, oi}, {16'h0, ei[15:0]});
        check({16'h0, oq}, {16'h0, eq[15:0]});
        // odd slots: eighth-turn r terms, or premodulated midpoints that cancel
        if (md == 4 || cw[3]) begin
          @(posedge core_clk_in);
          #1 check({16'h0, oi}, {16'h0, (md == 4) ? r45(ei + eq) : 16'h0000});
          check({16'h0, oq}, {16'h0, (md == 4) ? r45(eq - ei) : 16'h0000});
        end
        @(posedge core_clk_in);
        #1 rot(sm);
      end
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    hen <= 1'b1;
    rd_chk(`ICM_REG_CTRL, 32'h0);
    rd_chk(`ICM_REG_MODES, 32'h0);
    rd_chk(8'h20, 32'h0);
    wr_reg(`ICM_REG_TUNE, 32'h19999999);
    rd_chk(`ICM_REG_ACTIVE, 32'h0);
    wr_reg(`ICM_REG_UPDATE, 32'h1);
    rd_chk(`ICM_REG_ACTIVE, 32'h19999999);
    wr_reg(`ICM_REG_TUNE, 32'h12345678);
    wr_reg(`ICM_REG_UPDATE, 32'h1);
    rd_chk(`ICM_REG_ACTIVE, 32'h19999999);
    wr_reg(`ICM_REG_UPDATE, 32'h0);
    wr_reg(`ICM_REG_UPDATE, 32'h1);
    rd_chk(`ICM_REG_ACTIVE, 32'h12345678);
    for (m = 0; m < 8; m = m + 1) begin
      wr_reg(`ICM_REG_CTRL, m);
      if (m == 7)
        rd_chk(`ICM_REG_STATUS, 32'h00001049);
      n = 0;
      repeat (64) begin
        @(posedge core_clk_in);
        #1 n = n + srdy;
      end
      check(n, 64 >> (m % 2 + m / 2 % 2 + m / 4));
    end
    for (m = 1; m < 5; m = m + 1) stream(m, 1, m);
    stream(0, 9, 1);
    // a quarter-turn word at twice the data rate turns each output a further quarter
    wr_reg(`ICM_REG_TUNE, 32'h40000000);
    wr_reg(`ICM_REG_UPDATE, 32'h0);
    wr_reg(`ICM_REG_UPDATE, 32'h1);
    stream(0, 17, 3);
    stop_test;
  end
  // hang guard
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    stop_test;
  end
endmodule // tb_top
